// [include/pts_defs.svh]
// Register offsets, reset values, wrap limits and message codes of the
// time clock and stamp selection block.
// Assumes a 32-bit register port with byte offsets and the pts_pkg types.
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH
`define PTS_OFF_CTRL 8'h00
`define PTS_OFF_STEP 8'h04
`define PTS_OFF_ADDEND 8'h08
`define PTS_OFF_SEC 8'h0c
`define PTS_OFF_SUB 8'h10
`define PTS_OFF_ACC 8'h14
`define PTS_OFF_TSEC 8'h18
`define PTS_OFF_TSUB 8'h1c
`define PTS_CFG_W 12
`define PTS_CTRL_RST 12'h000
`define PTS_STEP_RST 32'h00000000
`define PTS_ADDEND_RST 32'h00000000
`define PTS_NS_LIMIT 32'h3ba9c9ff
`define PTS_BIN_LIMIT 32'h7fffffff
`define PTS_MT_SYNC 4'h0
`define PTS_MT_DREQ 4'h1
`define PTS_MT_PREQ 4'h2
`define PTS_MT_PRESP 4'h3
`define PTS_MT_FUP 4'h8
`define PTS_MT_DRESP 4'h9
`define PTS_VER_1 4'h1
`define PTS_VER_2 4'h2
`endif

// [include/pts_pkg.sv]
// Types shared by the time clock and stamp selection block.
// Assumes nothing beyond a SystemVerilog compiler.
package pts_pkg;
  typedef enum logic [3:0] {
    PTS_SEL_DEFAULT_FOUR = 4'h0,
    PTS_SEL_SYNC = 4'h1,
    PTS_SEL_DELAY_REQUEST = 4'h2,
    PTS_SEL_EVERY_MESSAGE = 4'h3,
    PTS_SEL_SYNC_PEER = 4'h4,
    PTS_SEL_DELAY_PEER = 4'h5,
    PTS_SEL_SYNC_DELAY = 4'h6,
    PTS_SEL_PEER_ONLY = 4'h7,
    PTS_SEL_NONE = 4'hf
  } pts_sel_t;

  typedef enum logic [1:0] {
    PTS_ENC_OTHER = 2'h0,
    PTS_ENC_UDP_V4 = 2'h1,
    PTS_ENC_UDP_V6 = 2'h2,
    PTS_ENC_RAW = 2'h3
  } pts_encap_t;

  // Control word, most significant field first.
  typedef struct packed {
    logic stampEveryRxFrame;
    logic acceptRawFrames;
    logic acceptUdpV6;
    logic acceptUdpV4;
    pts_sel_t stampSel;
    logic ptpAddrFilterOn;
    logic ptpFormatV2;
    logic nanosecondWrapSelect;
    logic fineUpdateSelect;
  } pts_cfg_t;

  typedef struct packed {
    logic valid;
    logic isPtp;
    pts_encap_t encap;
    logic [3:0] msgType;
    logic [3:0] version;
    logic dstMatch;
  } pts_frame_t;

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] sub;
  } pts_time_t;

  typedef struct packed {
    logic [31:0] acc;
    logic tick;
  } pts_acc_st_t;

  typedef struct packed {
    logic stamp;
    logic drop;
  } pts_flt_st_t;

  typedef struct packed {
    pts_cfg_t cfg;
    logic [31:0] subsecondStep;
    logic [31:0] addendValue;
    pts_time_t now;
    pts_time_t stamp;
    logic [31:0] rdData;
  } pts_main_st_t;
endpackage

// [src/pts_addend_acc.sv]
// Fine-mode addend accumulator; flags each carry out as a one-cycle tick.
// Assumes the addend comes from a register on the same clock.
`timescale 1ns/1ps
`include "pts_defs.svh"
module pts_addend_acc import pts_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [31:0] addendValue,
  output logic carryTick,
  output logic [31:0] accValue
);
  pts_acc_st_t st_r, st_nxt;
  logic [32:0] accSum;

  // The sum keeps its low word, so the remainder carries into the next tick.
  always_comb begin
    st_nxt = st_r;
    accSum = {1'b0, st_r.acc} + {1'b0, addendValue};
    st_nxt.tick = 1'b0;
    if (enable) begin
      st_nxt.acc = accSum[31:0];
      st_nxt.tick = accSum[32];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign carryTick = st_r.tick;
  assign accValue = st_r.acc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  acc_low_word_a: assert property (enable |=>
    accValue == $past(accSum[31:0]) && carryTick == $past(accSum[32]))
    else $error("accumulator did not keep the low word of the sum");
  acc_idle_a: assert property (!enable |=> !carryTick && $stable(accValue))
    else $error("accumulator moved while fine mode was off");
endmodule

// [src/pts_stamp_filter.sv]
// Decides per received frame whether it is stamped or discarded.
// Assumes the frame descriptor comes from the MAC parser on the same clock.
`timescale 1ns/1ps
`include "pts_defs.svh"
module pts_stamp_filter import pts_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input pts_cfg_t cfg,
  input pts_frame_t frame,
  output logic stampPulse,
  output logic dropPulse
);
  pts_flt_st_t st_r, st_nxt;
  logic encOk, fmtOk, ptpOk, addrOk, four;

  // Message set lookup; unused select codes stamp nothing.
  function automatic logic msgSelected(input pts_sel_t sel,
                                       input logic [3:0] mt);
    logic sync, dreq, peer;
    sync = mt == `PTS_MT_SYNC;
    dreq = mt == `PTS_MT_DREQ;
    peer = mt == `PTS_MT_PREQ || mt == `PTS_MT_PRESP;
    case (sel)
      PTS_SEL_DEFAULT_FOUR: msgSelected = sync || dreq ||
        mt == `PTS_MT_FUP || mt == `PTS_MT_DRESP;
      PTS_SEL_SYNC: msgSelected = sync;
      PTS_SEL_DELAY_REQUEST: msgSelected = dreq;
      PTS_SEL_EVERY_MESSAGE: msgSelected = 1'b1;
      PTS_SEL_SYNC_PEER: msgSelected = sync || peer;
      PTS_SEL_DELAY_PEER: msgSelected = dreq || peer;
      PTS_SEL_SYNC_DELAY: msgSelected = dreq;
      PTS_SEL_PEER_ONLY: msgSelected = peer;
      default: msgSelected = 1'b0;
    endcase
  endfunction

  // Classify the frame, then register the verdict.
  always_comb begin
    st_nxt = st_r;
    unique case (frame.encap)
      PTS_ENC_UDP_V4: encOk = cfg.acceptUdpV4;
      PTS_ENC_UDP_V6: encOk = cfg.acceptUdpV6;
      PTS_ENC_RAW: encOk = cfg.acceptRawFrames;
      PTS_ENC_OTHER: encOk = 1'b0;
    endcase
    fmtOk = frame.version == (cfg.ptpFormatV2 ? `PTS_VER_2 : `PTS_VER_1);
    ptpOk = frame.valid && frame.isPtp && encOk && fmtOk;
    addrOk = !cfg.ptpAddrFilterOn || frame.dstMatch;
    four = msgSelected(PTS_SEL_DEFAULT_FOUR, frame.msgType);
    if (cfg.stampEveryRxFrame && cfg.stampSel == PTS_SEL_NONE) begin
      st_nxt.stamp = ptpOk && addrOk && four;
    end else if (cfg.stampEveryRxFrame) begin
      st_nxt.stamp = frame.valid;
    end else begin
      st_nxt.stamp = ptpOk && addrOk &&
        msgSelected(cfg.stampSel, frame.msgType);
    end
    // A frame that is stamped in every-frame mode is never also discarded.
    st_nxt.drop = ptpOk && !addrOk &&
      !(cfg.stampEveryRxFrame && cfg.stampSel != PTS_SEL_NONE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stampPulse = st_r.stamp;
  assign dropPulse = st_r.drop;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  addr_drop_a: assert property (frame.valid && frame.isPtp && encOk &&
    fmtOk && cfg.ptpAddrFilterOn && !frame.dstMatch &&
    !cfg.stampEveryRxFrame |=> dropPulse && !stampPulse)
    else $error("unmatched PTP frame was not discarded");
  encap_off_a: assert property (frame.valid &&
    frame.encap == PTS_ENC_UDP_V4 && !cfg.acceptUdpV4 &&
    !cfg.stampEveryRxFrame |=> !stampPulse && !dropPulse)
    else $error("frame of a disabled encapsulation was processed");
  every_rx_a: assert property (frame.valid && cfg.stampEveryRxFrame &&
    cfg.stampSel != PTS_SEL_NONE |=> stampPulse && !dropPulse)
    else $error("received frame was not stamped in every-frame mode");
  four_only_a: assert property (frame.valid && cfg.stampEveryRxFrame &&
    cfg.stampSel == PTS_SEL_NONE && frame.msgType == `PTS_MT_PREQ
    |=> !stampPulse)
    else $error("peer request stamped with no subset chosen");
  format_a: assert property (frame.valid && !cfg.stampEveryRxFrame &&
    frame.version != (cfg.ptpFormatV2 ? `PTS_VER_2 : `PTS_VER_1)
    |=> !stampPulse)
    else $error("frame of the wrong format was stamped");
  sync_sel_a: assert property (frame.valid && !cfg.stampEveryRxFrame &&
    cfg.stampSel == PTS_SEL_SYNC && frame.msgType != `PTS_MT_SYNC
    |=> !stampPulse)
    else $error("non-SYNC message stamped in SYNC-only mode");
endmodule

// [src/pts_time_clock.sv]
// Top of the time clock: register port, seconds and subseconds counter,
// fine-mode accumulator and per-frame stamp selection.
// Assumes a register master and a MAC frame parser on the same clock.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pts_defs.svh"
module pts_time_clock import pts_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input pts_frame_t rxFrame,
  output pts_time_t timeNow,
  output pts_time_t stampTime,
  output logic stampPulse,
  output logic dropPulse
);
  pts_main_st_t st_r, st_nxt;

  logic accTick;
  logic [31:0] accValue;
  logic advance;
  logic [31:0] wrapLimit;
  logic [32:0] stepSum;
  logic timeWr;

  // Adds the step and folds the sum back under the wrap limit.
  // Bit 32 of the result marks a wrap, which carries into the seconds.
  // The excess over the limit is kept rather than dropped, so a step
  // that does not divide the second evenly keeps no long-term error.
  function automatic logic [32:0] wrapAdd(input logic [31:0] sub,
                                          input logic [31:0] step,
                                          input logic [31:0] lim);
    logic [32:0] sum;
    sum = {1'b0, sub} + {1'b0, step};
    if (sum > {1'b0, lim}) begin
      sum = {1'b1, 32'(sum - {1'b0, lim} - 33'h1)};
    end
    return sum;
  endfunction

  // The accumulator only runs in fine mode.
  pts_addend_acc u_acc (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(st_r.cfg.fineUpdateSelect),
    .addendValue(st_r.addendValue),
    .carryTick(accTick),
    .accValue(accValue)
  );

  // Frame verdicts come out one cycle after the descriptor.
  pts_stamp_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg(st_r.cfg),
    .frame(rxFrame),
    .stampPulse(stampPulse),
    .dropPulse(dropPulse)
  );

  // A software write of either time word takes over that word's advance; the other word still advances.
  assign timeWr = regWrStb &&
    (regAddr == `PTS_OFF_SEC || regAddr == `PTS_OFF_SUB);

  // The tick source and wrap limit follow the live configuration.
  always_comb begin
    if (st_r.cfg.fineUpdateSelect) begin
      advance = accTick;
    end else begin
      advance = 1'b1;
    end
    if (st_r.cfg.nanosecondWrapSelect) begin
      wrapLimit = `PTS_NS_LIMIT;
    end else begin
      wrapLimit = `PTS_BIN_LIMIT;
    end
    stepSum = wrapAdd(st_r.now.sub, st_r.subsecondStep, wrapLimit);
  end

  // Next state: time advance, frame capture, register writes and reads.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdData = 32'h00000000;

    // Advance by the step on each tick.
    if (advance) begin
      st_nxt.now.sub = stepSum[31:0];
      if (stepSum[32]) begin
        st_nxt.now.sec = st_r.now.sec + 32'h00000001;
      end
    end

    // The time of every described frame is held until the next one.
    if (rxFrame.valid) begin
      st_nxt.stamp = st_r.now;
    end

    // Writes. The addend may change at any time; the accumulator
    // simply uses the new value from the next clock on.
    if (regWrStb) begin
      case (regAddr)
        `PTS_OFF_CTRL: begin
          st_nxt.cfg = pts_cfg_t'(regWrData[`PTS_CFG_W-1:0]);
        end
        `PTS_OFF_STEP: begin
          st_nxt.subsecondStep = regWrData;
        end
        `PTS_OFF_ADDEND: begin
          st_nxt.addendValue = regWrData;
        end
        `PTS_OFF_SEC: begin
          st_nxt.now.sec = regWrData;
        end
        `PTS_OFF_SUB: begin
          // An out-of-range value loads zero, so the wrap stays exact.
          if (regWrData > wrapLimit) begin
            st_nxt.now.sub = 32'h00000000;
          end else begin
            st_nxt.now.sub = regWrData;
          end
        end
        default: begin
        end
      endcase
    end

    // Reads answer in the next cycle only; unmapped offsets read zero.
    if (regRdStb) begin
      case (regAddr)
        `PTS_OFF_CTRL: begin
          st_nxt.rdData = {20'h00000, st_r.cfg};
        end
        `PTS_OFF_STEP: begin
          st_nxt.rdData = st_r.subsecondStep;
        end
        `PTS_OFF_ADDEND: begin
          st_nxt.rdData = st_r.addendValue;
        end
        `PTS_OFF_SEC: begin
          st_nxt.rdData = st_r.now.sec;
        end
        `PTS_OFF_SUB: begin
          st_nxt.rdData = st_r.now.sub;
        end
        `PTS_OFF_ACC: begin
          st_nxt.rdData = accValue;
        end
        `PTS_OFF_TSEC: begin
          st_nxt.rdData = st_r.stamp.sec;
        end
        `PTS_OFF_TSUB: begin
          st_nxt.rdData = st_r.stamp.sub;
        end
        default: begin
          st_nxt.rdData = 32'h00000000;
        end
      endcase
    end
  end

  // This module's state lives in one register; reset clears the time and stops
  // the clock, since a zero step does not move it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.cfg <= pts_cfg_t'(`PTS_CTRL_RST);
      st_r.cfg.stampSel <= PTS_SEL_DEFAULT_FOUR;
      st_r.subsecondStep <= `PTS_STEP_RST;
      st_r.addendValue <= `PTS_ADDEND_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign timeNow = st_r.now;
  assign stampTime = st_r.stamp;

  // Checks on the counter, the register port and the frame time capture.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  fine_hold_a: assert property (
    st_r.cfg.fineUpdateSelect && !accTick && !timeWr
    |=> $stable(timeNow))
    else $error("time moved in fine mode without a carry");

  fine_step_a: assert property (
    st_r.cfg.fineUpdateSelect && accTick && !timeWr &&
    !stepSum[32] |=> timeNow.sub == $past(st_r.now.sub) +
    $past(st_r.subsecondStep))
    else $error("fine carry did not add the step");

  coarse_step_a: assert property (
    !st_r.cfg.fineUpdateSelect && !timeWr && !stepSum[32]
    |=> timeNow.sub == $past(st_r.now.sub) + $past(st_r.subsecondStep))
    else $error("coarse mode did not add the step each clock");

  ns_range_a: assert property (
    st_r.cfg.nanosecondWrapSelect && timeNow.sub <= `PTS_NS_LIMIT &&
    !(regWrStb && regAddr == `PTS_OFF_CTRL)
    |=> timeNow.sub <= `PTS_NS_LIMIT)
    else $error("subseconds passed the nanosecond limit");

  bin_range_a: assert property (
    !st_r.cfg.nanosecondWrapSelect && timeNow.sub <= `PTS_BIN_LIMIT &&
    !(regWrStb && regAddr == `PTS_OFF_CTRL)
    |=> timeNow.sub <= `PTS_BIN_LIMIT)
    else $error("subseconds passed the binary limit");

  sec_carry_a: assert property (
    advance && !timeWr && stepSum[32]
    |=> timeNow.sec == $past(st_r.now.sec) + 32'h00000001 &&
    timeNow.sub < $past(st_r.now.sub) + 32'h00000001)
    else $error("seconds did not follow a subsecond wrap");

  step_readback_a: assert property (
    regWrStb && regAddr == `PTS_OFF_STEP ##1
    regRdStb && regAddr == `PTS_OFF_STEP && !regWrStb
    |=> regRdData == $past(regWrData, 2))
    else $error("step did not read back as written");

  addend_live_a: assert property (
    regWrStb && regAddr == `PTS_OFF_ADDEND
    |=> st_r.addendValue == $past(regWrData))
    else $error("addend write was not taken");

  sub_clamp_a: assert property (
    regWrStb && regAddr == `PTS_OFF_SUB && regWrData > wrapLimit
    |=> timeNow.sub == 32'h00000000)
    else $error("out-of-range subsecond write did not load zero");

  stamp_capture_a: assert property (
    rxFrame.valid |=> stampTime == $past(timeNow))
    else $error("frame time was not captured");

  rd_only_once_a: assert property (!regRdStb |=> regRdData == 32'h0)
    else $error("read data stood outside its cycle");

  wrap_seen_c: cover property (advance && stepSum[32] && !timeWr);
  fine_tick_c: cover property (st_r.cfg.fineUpdateSelect && accTick);
  stamp_seen_c: cover property (stampPulse);
  drop_seen_c: cover property (dropPulse);
endmodule

// [dv/ptp_time_clock_and_stamp_select_bench.sv]
// Self-checking bench for the time clock and per-frame stamp selection.
// Assumes pts_pkg and pts_defs.svh are on the include path; one clock.
`timescale 1ns/1ps
`include "pts_defs.svh"
module ptp_time_clock_and_stamp_select_bench
  import pts_pkg::*;
;
  logic clk;
  logic sysRst;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic [31:0] regRdData;
  logic regWrStb;
  logic regRdStb;
  pts_frame_t rxFrame;
  pts_time_t timeNow;
  pts_time_t stampTime;
  logic stampPulse;
  logic dropPulse;
  int nFail = 0;
  int totalChecks = 0;
  logic [31:0] rdQ[$];
  logic [1:0] vQ[$];
  logic rdPend = 1'h0;
  logic fPend = 1'h0;
  logic [31:0] step;
  pts_time_t stampExp;
  pts_cfg_t cfg;
  pts_frame_t f;
  logic [3:0] mts[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};

  pts_time_clock i_dut (
    .clk(clk),
    .sys_rst(sysRst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStb(regWrStb),
    .regRdStb(regRdStb),
    .regRdData(regRdData),
    .rxFrame(rxFrame),
    .timeNow(timeNow),
    .stampTime(stampTime),
    .stampPulse(stampPulse),
    .dropPulse(dropPulse)
  );

  // A 200 MHz clock.
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'h1;
    @(posedge clk);
    regWrStb <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rdQ.push_back(e);
    regAddr <= a;
    regRdStb <= 1'h1;
    @(posedge clk);
    regRdStb <= 1'h0;
  endtask

  // Expected stamp and drop flags of one frame under a control word.
  function automatic logic [1:0] verdict(pts_cfg_t c, pts_frame_t x);
    logic ptpOk;
    logic addrOk;
    logic inSet;
    logic four;
    logic [3:0] en;
    four = x.msgType inside {4'h0, 4'h1, 4'h8, 4'h9};
    case (c.stampSel)
      PTS_SEL_DEFAULT_FOUR: inSet = four;
      PTS_SEL_SYNC: inSet = x.msgType == 4'h0;
      PTS_SEL_DELAY_REQUEST, PTS_SEL_SYNC_DELAY: inSet = x.msgType == 4'h1;
      PTS_SEL_EVERY_MESSAGE: inSet = 1'h1;
      PTS_SEL_SYNC_PEER: inSet = x.msgType inside {4'h0, 4'h2, 4'h3};
      PTS_SEL_DELAY_PEER: inSet = x.msgType inside {4'h1, 4'h2, 4'h3};
      PTS_SEL_PEER_ONLY: inSet = x.msgType inside {4'h2, 4'h3};
      default: inSet = 1'h0;
    endcase
    en = {c.acceptRawFrames, c.acceptUdpV6, c.acceptUdpV4, 1'h0};
    ptpOk = x.isPtp && en[x.encap] &&
            x.version == (c.ptpFormatV2 ? 4'h2 : 4'h1);
    addrOk = !c.ptpAddrFilterOn || x.dstMatch;
    if (c.stampEveryRxFrame && c.stampSel != PTS_SEL_NONE) return 2'h2;
    if (c.stampEveryRxFrame) inSet = four;
    return {ptpOk && addrOk && inSet, ptpOk && !addrOk};
  endfunction

  // Each cycle's time must follow from the previous one by one step.
  task automatic tcheck(input int n, input logic [31:0] lim);
    pts_time_t p;
    pts_time_t e;
    logic [32:0] s;
    @(posedge clk);
    p = timeNow;
    repeat (n) begin
      @(posedge clk);
      s = p.sub + step;
      e.sec = p.sec;
      e.sub = s[31:0];
      if (s > {1'h0, lim}) begin
        e.sub = 32'(s - lim - 33'h1);
        e.sec = p.sec + 32'h1;
      end
      chk(timeNow, e);
      p = timeNow;
    end
  endtask

  // Counts fine-mode advances over a window that spans whole carry periods.
  task automatic fcount(input int n, input int exp);
    int cnt;
    pts_time_t p;
    cnt = 0;
    @(posedge clk);
    p = timeNow;
    repeat (n) begin
      @(posedge clk);
      if (timeNow.sub !== p.sub) begin
        cnt++;
        chk(timeNow.sub, p.sub + step);
      end
      p = timeNow;
    end
    chk(cnt, exp);
  endtask

  // Output watcher: read data only in the cycle after a read, else zero.
  // Outputs are unknown until the first reset edge, so reset is skipped.
  always @(posedge clk) begin
    if (!sysRst) begin
      if (rdPend) chk(regRdData, rdQ.pop_front());
      else chk(regRdData, 32'h0);
      if (fPend) begin
        chk(stampTime, stampExp);
        chk({stampPulse, dropPulse}, vQ.pop_front());
      end else begin
        chk({stampPulse, dropPulse}, 2'h0);
      end
    end
    rdPend = regRdStb;
    fPend = rxFrame.valid;
  end

  // Watchdog sized well beyond the fewer than a thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    end_sim();
  end

  initial begin
    sysRst = 1'h1;
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWrStb = 1'h0;
    regRdStb = 1'h0;
    rxFrame = '0;
    void'($urandom(32'h49c0));
    repeat (10) @(posedge clk);
    sysRst <= 1'h0;
    // Every register, and one unmapped place, reads zero after reset.
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
    // Write then read of the step with no idle cycle between the strobes.
    @(posedge clk);
    regAddr <= `PTS_OFF_STEP;
    regWrData <= 32'h00000123;
    regWrStb <= 1'h1;
    @(posedge clk);
    regWrStb <= 1'h0;
    regRdStb <= 1'h1;
    rdQ.push_back(32'h00000123);
    @(posedge clk);
    regRdStb <= 1'h0;
    step = 32'h100;
    wr(`PTS_OFF_STEP, step);
    wr(`PTS_OFF_SUB, `PTS_BIN_LIMIT - 32'h180);
    tcheck(4, `PTS_BIN_LIMIT);
    step = 32'h5;
    wr(`PTS_OFF_STEP, step);
    wr(`PTS_OFF_CTRL, 32'h2);
    // A subsecond value past the nanosecond limit loads zero, then steps.
    wr(`PTS_OFF_SUB, `PTS_BIN_LIMIT);
    rd(`PTS_OFF_SUB, step);
    wr(`PTS_OFF_SUB, `PTS_NS_LIMIT - 32'h7);
    tcheck(6, `PTS_NS_LIMIT);
    // Random steps and start points in both wrap modes.
    for (int i = 0; i < 4; i++) begin
      step = $urandom_range(1, 32'h00ffffff);
      wr(`PTS_OFF_CTRL, {30'h0, i[0], 1'h0});
      wr(`PTS_OFF_STEP, step);
      wr(`PTS_OFF_SUB, $urandom_range(0, `PTS_NS_LIMIT));
      tcheck(8, i[0] ? `PTS_NS_LIMIT : `PTS_BIN_LIMIT);
    end
    // Fine mode at half rate, then a rate trimmed while running.
    step = 32'h50;
    wr(`PTS_OFF_STEP, step);
    wr(`PTS_OFF_ADDEND, 32'h80000000);
    wr(`PTS_OFF_SUB, 32'h0);
    wr(`PTS_OFF_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    fcount(40, 20);
    wr(`PTS_OFF_ADDEND, 32'h60000000);
    repeat (4) @(posedge clk);
    fcount(64, 24);
    rd(`PTS_OFF_ADDEND, 32'h60000000);
    // Frozen time so that every stamp has a known value.
    step = 32'h0;
    wr(`PTS_OFF_CTRL, 32'h0);
    wr(`PTS_OFF_STEP, step);
    wr(`PTS_OFF_SEC, 32'h12345678);
    wr(`PTS_OFF_SUB, 32'h00abcdef);
    stampExp = {32'h12345678, 32'h00abcdef};
    for (int i = 0; i < 20; i++) begin
      cfg = pts_cfg_t'(12'($urandom));
      cfg.fineUpdateSelect = 1'h0;
      cfg.stampEveryRxFrame = i[0];
      cfg.stampSel = pts_sel_t'(i < 16 ? i / 2 : (i < 18 ? 15 : 11));
      wr(`PTS_OFF_CTRL, {20'h0, cfg});
      rd(`PTS_OFF_CTRL, {20'h0, cfg});
      repeat (30) begin
        @(posedge clk);
        f.valid = $urandom_range(0, 3) != 0;
        f.isPtp = $urandom_range(0, 5) != 0;
        f.encap = pts_encap_t'($urandom_range(0, 3));
        f.msgType = mts[$urandom_range(0, 5)];
        f.version = 4'($urandom_range(1, 2));
        f.dstMatch = 1'($urandom_range(0, 1));
        rxFrame <= f;
        if (f.valid) vQ.push_back(verdict(cfg, f));
      end
      @(posedge clk);
      rxFrame <= '0;
    end
    // Stamp registers are read-only; a write leaves them alone.
    wr(`PTS_OFF_TSEC, 32'hdeadbeef);
    rd(`PTS_OFF_TSEC, 32'h12345678);
    rd(`PTS_OFF_TSUB, 32'h00abcdef);
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule
